/* src/arf_pkg.sv */
// constants for the converter result formatter
package arf_pkg;
  localparam int unsigned ADDR_W      = 4;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned RES_W       = 12;

  // register indices (byte addresses on the plain port)
  localparam logic [3:0] ADDR_CTRL_A  = 4'h0;
  localparam logic [3:0] ADDR_CTRL_B  = 4'h1;
  localparam logic [3:0] ADDR_CTRL_C  = 4'h2;
  localparam logic [3:0] ADDR_RES_HI  = 4'h3;
  localparam logic [3:0] ADDR_RES_LO  = 4'h4;

  // control a fields
  localparam int unsigned BIT_WIDTH_MODE = 7;
  localparam int unsigned BIT_BUSY       = 1;
  localparam int unsigned BIT_ENABLE     = 0;
  // control b fields
  localparam int unsigned BIT_FORMAT     = 7;
  localparam logic [7:0]  CTRL_B_MASK    = 8'hF7;

  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [7:0]  READ_UNMAPPED  = 8'h00;
  localparam logic [2:0]  SM_ZERO_BITS   = 3'h0;

  // channel select fields
  localparam int unsigned POS_CHAN_LSB   = 2;
  localparam int unsigned POS_CHAN_MSB   = 6;
  localparam int unsigned NEG_CHAN_LSB   = 0;
  localparam int unsigned NEG_CHAN_MSB   = 3;

  // result field positions, sign-magnitude and twos complement
  localparam int unsigned SM_HI_MSB      = 11;
  localparam int unsigned SM_HI_LSB      = 4;
  localparam int unsigned SM_LO_MSB      = 3;
  localparam int unsigned SM_LO_LSB      = 0;
  localparam int unsigned TC_HI_MSB      = 11;
  localparam int unsigned TC_HI_LSB      = 8;
  localparam int unsigned TC_LO_MSB      = 7;
  localparam int unsigned TC_LO_LSB      = 0;
  localparam int unsigned SIGN_EXT_W     = 4;
  localparam logic [11:0] TWOS_ONE       = 12'h001;
endpackage : arf_pkg

/* src/arf_result_formatter.sv */
// result formatting and control registers of the differential converter
`timescale 1ns/1ps

// Summary of operation
// R01: sign-magnitude: low nibble of magnitude in low[7:4]
// R02: sign-magnitude: low[3:1] written zero
// R03: sign-magnitude: sign in low bit 0
// R04: twos complement: high[7:4] copies of sign
// R05: twos complement: result[11:8] in high[3:0]
// R06: twos complement: result[7:0] in low byte
// R07: result registers read/write, unknown at power-on, kept across reset
// R08: software waits acquisition before starting conversion
// R09: format bit one twos, zero sign-magnitude
// R10: sign-magnitude: result[11:4] in high byte
// R11: hardware clears busy bit on completion
// R12: results load same cycle busy clears
module arf_result_formatter (
  // clock, reset, enable
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_ce,
  // register port
  input  wire logic [3:0]           i_addr,
  input  wire logic [7:0]           i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output logic      [7:0]           o_rdata,
  // converter core
  input  wire logic                 i_conv_done,
  input  wire logic [11:0]          i_conv_mag,
  input  wire logic                 i_conv_sign,
  output logic                      o_conv_start,
  output logic                      o_converter_enable,
  output logic      [4:0]           o_positive_channel_select,
  output logic      [3:0]           o_negative_channel_select,
  output logic                      o_result_width_mode
);

  // control registers and their next values
  logic [7:0]  ctrl_a_q;
  logic [7:0]  ctrl_a_d;
  logic [7:0]  ctrl_b_q;
  logic [7:0]  ctrl_b_d;
  logic [7:0]  ctrl_c_q;
  logic [7:0]  ctrl_c_d;
  // result registers and their next values
  logic [7:0]  res_hi_q;
  logic [7:0]  res_hi_d;
  logic [7:0]  res_lo_q;
  logic [7:0]  res_lo_d;
  // read port and start pulse
  logic [7:0]  rdata_q;
  logic [7:0]  rdata_d;
  logic        start_q;
  logic        start_d;
  // one-hot address decode of the strobes
  logic        wr_ctrl_a;
  logic        wr_ctrl_b;
  logic        wr_ctrl_c;
  logic        wr_res_hi;
  logic        wr_res_lo;
  logic        rd_ctrl_a;
  logic        rd_ctrl_b;
  logic        rd_ctrl_c;
  logic        rd_res_hi;
  logic        rd_res_lo;
  logic        rd_unmapped;
  // formatted result in both encodings
  logic [7:0]  sm_hi;
  logic [7:0]  sm_lo;
  logic [7:0]  tc_hi;
  logic [7:0]  tc_lo;
  logic [11:0] twos;
  logic [7:0]  fmt_hi;
  logic [7:0]  fmt_lo;
  logic        result_format_select;
  logic        busy;
  logic        conv_finish;
  logic        start_req;

  assign result_format_select = ctrl_b_q[arf_pkg::BIT_FORMAT];
  assign busy                 = ctrl_a_q[arf_pkg::BIT_BUSY];
  // a done pulse counts only while a conversion is in progress
  assign conv_finish          = i_conv_done & busy;

  // write decode; unmapped addresses select nothing
  always_comb
  begin
    wr_ctrl_a = 1'b0;
    wr_ctrl_b = 1'b0;
    wr_ctrl_c = 1'b0;
    wr_res_hi = 1'b0;
    wr_res_lo = 1'b0;
    if (i_wr)
    begin
      unique case (i_addr)
        arf_pkg::ADDR_CTRL_A: wr_ctrl_a = 1'b1;
        arf_pkg::ADDR_CTRL_B: wr_ctrl_b = 1'b1;
        arf_pkg::ADDR_CTRL_C: wr_ctrl_c = 1'b1;
        arf_pkg::ADDR_RES_HI: wr_res_hi = 1'b1;                        // see R07
        arf_pkg::ADDR_RES_LO: wr_res_lo = 1'b1;                        // see R07
        default: ;
      endcase
    end
  end

  // read decode; an unmapped read returns a fixed value
  always_comb
  begin
    rd_ctrl_a   = 1'b0;
    rd_ctrl_b   = 1'b0;
    rd_ctrl_c   = 1'b0;
    rd_res_hi   = 1'b0;
    rd_res_lo   = 1'b0;
    rd_unmapped = 1'b0;
    if (i_rd)
    begin
      unique case (i_addr)
        arf_pkg::ADDR_CTRL_A: rd_ctrl_a = 1'b1;
        arf_pkg::ADDR_CTRL_B: rd_ctrl_b = 1'b1;
        arf_pkg::ADDR_CTRL_C: rd_ctrl_c = 1'b1;
        arf_pkg::ADDR_RES_HI: rd_res_hi = 1'b1;                        // see R07
        arf_pkg::ADDR_RES_LO: rd_res_lo = 1'b1;                        // see R07
        default:              rd_unmapped = 1'b1;
      endcase
    end
  end

  // sign-magnitude packing: magnitude left-justified, sign in the last bit
  always_comb
  begin
    sm_hi = i_conv_mag[arf_pkg::SM_HI_MSB:arf_pkg::SM_HI_LSB];                // see R10
    sm_lo = {i_conv_mag[arf_pkg::SM_LO_MSB:arf_pkg::SM_LO_LSB],               // see R01
             arf_pkg::SM_ZERO_BITS,                                         // see R02
             i_conv_sign};                                                  // see R03
  end

  // the core hands over magnitude and sign; twos form is derived here
  always_comb
  begin
    twos = i_conv_mag;
    if (i_conv_sign)
    begin
      twos = 12'(~i_conv_mag + arf_pkg::TWOS_ONE);
    end
    tc_hi = {{arf_pkg::SIGN_EXT_W{i_conv_sign}},                             // see R04
             twos[arf_pkg::TC_HI_MSB:arf_pkg::TC_HI_LSB]};                  // see R05
    tc_lo = twos[arf_pkg::TC_LO_MSB:arf_pkg::TC_LO_LSB];                    // see R06
  end

  // format select picks the encoding used at completion
  always_comb
  begin
    if (result_format_select)                                          // see R09
    begin
      fmt_hi = tc_hi;
      fmt_lo = tc_lo;
    end
    else
    begin
      fmt_hi = sm_hi;
      fmt_lo = sm_lo;
    end
  end

  // control a: software write, busy cleared by hardware on completion
  always_comb
  begin
    ctrl_a_d = ctrl_a_q;
    if (wr_ctrl_a)
    begin
      ctrl_a_d = i_wdata;
    end
    // completion wins over a software write in the same cycle
    if (conv_finish)
    begin
      ctrl_a_d[arf_pkg::BIT_BUSY] = 1'b0;                              // see R11
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ctrl_a_q <= arf_pkg::CTRL_RESET;
    end
    else if (i_ce)
    begin
      ctrl_a_q <= ctrl_a_d;
    end
  end

  // control b: the unimplemented bit always reads zero
  always_comb
  begin
    ctrl_b_d = ctrl_b_q;
    if (wr_ctrl_b)
    begin
      ctrl_b_d = i_wdata & arf_pkg::CTRL_B_MASK;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ctrl_b_q <= arf_pkg::CTRL_RESET;
    end
    else if (i_ce)
    begin
      ctrl_b_q <= ctrl_b_d;
    end
  end

  // control c: plain storage
  always_comb
  begin
    ctrl_c_d = ctrl_c_q;
    if (wr_ctrl_c)
    begin
      ctrl_c_d = i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ctrl_c_q <= arf_pkg::CTRL_RESET;
    end
    else if (i_ce)
    begin
      ctrl_c_q <= ctrl_c_d;
    end
  end

  // a start needs the converter on and idle; a start while busy is dropped
  always_comb
  begin
    start_req = i_wdata[arf_pkg::BIT_BUSY] & i_wdata[arf_pkg::BIT_ENABLE];
    start_d   = wr_ctrl_a & start_req & ~busy;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      start_q <= 1'b0;
    end
    else if (i_ce)
    begin
      start_q <= start_d;
    end
  end

  // results: completion load wins over a software write in the same cycle
  always_comb
  begin
    res_hi_d = res_hi_q;
    res_lo_d = res_lo_q;
    if (wr_res_hi)
    begin
      res_hi_d = i_wdata;                                              // see R07
    end
    if (wr_res_lo)
    begin
      res_lo_d = i_wdata;                                              // see R07
    end
    if (conv_finish)
    begin
      // same cycle as the busy clear, so polling never sees stale data
      res_hi_d = fmt_hi;                                               // see R12
      res_lo_d = fmt_lo;                                               // see R12
    end
  end

  // no reset: unknown at power-on and kept across every reset
  always_ff @(posedge i_ref_clk)
  begin
    if (i_ce)
    begin
      res_hi_q <= res_hi_d;                                            // see R07
      res_lo_q <= res_lo_d;                                            // see R07
    end
  end

  // read data stand in the cycle after the strobe and hold until the next read
  always_comb
  begin
    rdata_d = rdata_q;
    if (rd_ctrl_a)
    begin
      rdata_d = ctrl_a_q;
    end
    else if (rd_ctrl_b)
    begin
      rdata_d = ctrl_b_q;
    end
    else if (rd_ctrl_c)
    begin
      rdata_d = ctrl_c_q;
    end
    else if (rd_res_hi)
    begin
      rdata_d = res_hi_q;                                              // see R07
    end
    else if (rd_res_lo)
    begin
      rdata_d = res_lo_q;                                              // see R07
    end
    else if (rd_unmapped)
    begin
      rdata_d = arf_pkg::READ_UNMAPPED;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rdata_q <= arf_pkg::CTRL_RESET;
    end
    else if (i_ce)
    begin
      rdata_q <= rdata_d;
    end
  end

  // converter core controls come straight from the control flops
  assign o_rdata                   = rdata_q;
  assign o_conv_start              = start_q;
  assign o_converter_enable        = ctrl_a_q[arf_pkg::BIT_ENABLE];
  assign o_positive_channel_select = ctrl_a_q[arf_pkg::POS_CHAN_MSB:arf_pkg::POS_CHAN_LSB];
  assign o_negative_channel_select = ctrl_c_q[arf_pkg::NEG_CHAN_MSB:arf_pkg::NEG_CHAN_LSB];
  assign o_result_width_mode       = ctrl_a_q[arf_pkg::BIT_WIDTH_MODE];

endmodule : arf_result_formatter

/* tb/arf_checker.sv */
// port assertions for the result formatter
`timescale 1ns/1ps
module arf_checker (
  input wire logic i_ref_clk, i_rst, i_ce, i_wr, i_rd, i_conv_done, i_conv_sign,
  input wire logic [3:0] i_addr, o_negative_channel_select,
  input wire logic [7:0] i_wdata, o_rdata,
  input wire logic [11:0] i_conv_mag,
  input wire logic [4:0] o_positive_channel_select,
  input wire logic o_conv_start, o_converter_enable, o_result_width_mode
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  wire logic wa = i_ce && i_wr && i_addr == arf_pkg::ADDR_CTRL_A;
  start_pulse_a: assert property (o_conv_start |=> !o_conv_start) else $error("long start");
  start_cause_a: assert property
    ($rose(o_conv_start) |-> $past(wa && i_wdata[1:0] == 2'h3)) else $error("stray start");
  enable_out_a: assert property (wa |=> o_converter_enable == $past(i_wdata[0])) else $error("en");
  pos_chan_a: assert property (wa |=> o_positive_channel_select == $past(i_wdata[6:2]))
    else $error("pos chan");
  width_out_a: assert property (wa |=> o_result_width_mode == $past(i_wdata[7])) else $error("wm");
  neg_chan_a: assert property (i_wr && i_addr == arf_pkg::ADDR_CTRL_C
    |=> o_negative_channel_select == $past(i_wdata[3:0])) else $error("neg chan");
  unmapped_rd_a: assert property (i_rd && i_addr > arf_pkg::ADDR_RES_LO |=> o_rdata == 8'h00)
    else $error("unmapped");
  rdata_hold_a: assert property (!i_rd |=> $stable(o_rdata)) else $error("rdata moved");
  cover property (o_conv_start);
  cover property (i_conv_done && i_conv_sign);
  cover property (i_rd && i_addr == arf_pkg::ADDR_RES_LO);
endmodule : arf_checker
bind arf_result_formatter arf_checker u_chk (.*);

/* tb/arf_core_model.sv */
// converter core stand-in answering a start after six cycles
`timescale 1ns/1ps
module arf_core_model (
  input wire logic i_ref_clk, i_start, i_sign,
  input wire logic [11:0] i_mag,
  output logic o_done = 1'b0, o_sign = 1'b0,
  output logic [11:0] o_mag = 12'h000
);
  int n = 0;
  // result lines toggle outside the done pulse so a late sample fails
  always @(posedge i_ref_clk)
  begin
    o_done <= n == 1;
    o_mag <= n == 1 ? i_mag : ~o_mag;
    o_sign <= n == 1 ? i_sign : ~o_sign;
    n <= i_start ? 6 : (n > 0 ? n - 1 : 0);
  end
endmodule : arf_core_model

/* tb/tb_arf_result_formatter.sv */
// self-checking bench for the result formatter
`timescale 1ns/1ps
module tb_arf_result_formatter;
  logic i_ref_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, done, sgn, s_sign = 0, o_conv_start;
  logic ce = 1;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00, o_rdata, d;
  logic [11:0] mag, s_mag = 12'h000;
  int err_total = 0, samples_checked = 0, n;
  // format, magnitude, sign, expected high and low bytes
  logic [29:0] rows [4] = '{{1'h0, 12'hABC, 1'h1, 16'hABC1}, {1'h1, 12'h123, 1'h0, 16'h0123},
    {1'h1, 12'h001, 1'h1, 16'hFFFF}, {1'h1, 12'h800, 1'h1, 16'hF800}};
  always #2 i_ref_clk = ~i_ref_clk;
  arf_result_formatter DUT (.i_ref_clk, .i_rst, .i_ce(ce), .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_conv_done(done), .i_conv_mag(mag), .i_conv_sign(sgn), .o_conv_start,
    .o_converter_enable(), .o_positive_channel_select(), .o_negative_channel_select(),
    .o_result_width_mode());
  arf_core_model u_core (.i_ref_clk, .i_start(o_conv_start), .i_sign(s_sign), .i_mag(s_mag),
    .o_done(done), .o_sign(sgn), .o_mag(mag));
  task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
    samples_checked++;
    if (s !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(logic [3:0] a, logic [7:0] v);
    @(posedge i_ref_clk);
    {i_wr, i_addr, i_wdata} <= {1'b1, a, v};
    @(posedge i_ref_clk);
    i_wr <= 0;
  endtask : wr
  task automatic rd(logic [3:0] a);
    @(posedge i_ref_clk);
    {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_ref_clk);
    i_rd <= 0;
    #1 d = o_rdata;
  endtask : rd
  task automatic report_and_stop();
    if (err_total == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (10) @(posedge i_ref_clk);
    i_rst <= 0;
    rd(arf_pkg::ADDR_CTRL_A);
    chk("ctrl_a", d, arf_pkg::CTRL_RESET);
    wr(arf_pkg::ADDR_CTRL_B, 8'hFF);
    wr(arf_pkg::ADDR_CTRL_C, 8'h0F);
    rd(arf_pkg::ADDR_CTRL_B);
    chk("ctrl_b", d, arf_pkg::CTRL_B_MASK);
    rd(4'hF);
    chk("unmapped", d, arf_pkg::READ_UNMAPPED);
    foreach (rows[i])
    begin
      {s_mag, s_sign} <= rows[i][28:16];
      wr(arf_pkg::ADDR_CTRL_B, {rows[i][29], 7'h00});
      wr(arf_pkg::ADDR_CTRL_A, 8'h7F);
      n = 0;
      do begin rd(arf_pkg::ADDR_CTRL_A); n++; end while (d[1] !== 1'b0 && n < 20);
      if (d[1] !== 1'b0) begin err_total++; report_and_stop(); end
      rd(arf_pkg::ADDR_RES_HI);
      chk("result_high", d, rows[i][15:8]);
      rd(arf_pkg::ADDR_RES_LO);
      chk("result_low", d, rows[i][7:0]);
    end
    wr(arf_pkg::ADDR_RES_HI, 8'h5A);
    i_rst <= 1;
    @(posedge i_ref_clk);
    i_rst <= 0;
    rd(arf_pkg::ADDR_RES_HI);
    chk("result_kept", d, 8'h5A);
    // a write while the clock enable is low must leave the register untouched
    ce <= 0;
    wr(arf_pkg::ADDR_RES_HI, 8'hA5);
    ce <= 1;
    rd(arf_pkg::ADDR_RES_HI);
    chk("result_frozen", d, 8'h5A);
    wr(arf_pkg::ADDR_CTRL_A, 8'h02);
    #1 chk("start_refused", {7'h00, o_conv_start}, 8'h00);
    report_and_stop();
  end
endmodule : tb_arf_result_formatter
